// File: rtl/nsx_pkg.sv
// Purpose: Shared constants and types for the nibble-swap / exclusive-OR / direction-load executor
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file register addresses
// Notes: Opcode values are field patterns compared against the top bits of the word
package nsx_pkg;
  localparam int NSX_DATA_W = 8;
  localparam int NSX_WORD_W = 14;
  localparam int NSX_ADDR_W = 7;
  localparam int NSX_DIR_SEL_W = 3;
  // Field positions inside the instruction word
  localparam int NSX_OPC_MSB = 13;
  localparam int NSX_OPC_LSB = 8;
  localparam int NSX_DIR_OPC_LSB = 3;
  localparam int NSX_DEST_BIT = 7;
  // Opcode patterns
  localparam logic [5:0] NSX_OPC_SWAP = 6'h0E;
  localparam logic [5:0] NSX_OPC_RXOR = 6'h06;
  localparam logic [5:0] NSX_OPC_LXOR = 6'h3A;
  localparam logic [10:0] NSX_OPC_DIR = 11'h00C;
  // Legal direction register selectors
  localparam logic [2:0] NSX_DIR_MIN = 3'h5;
  localparam logic [2:0] NSX_DIR_MAX = 3'h7;
  // Values after reset, and the all-zero data byte
  localparam logic [7:0] NSX_ACC_RST = 8'h00;
  localparam logic NSX_ZERO_RST = 1'b0;
  localparam logic [7:0] NSX_ZERO_BYTE = 8'h00;
  // Phases of one instruction cycle
  typedef enum logic [3:0] {
    NSX_Q1 = 4'h1,
    NSX_Q2 = 4'h2,
    NSX_Q3 = 4'h4,
    NSX_Q4 = 4'h8
  } nsx_phase_e;
  // Decoded operations
  typedef enum logic [2:0] {
    NSX_OP_NONE = 3'h0,
    NSX_OP_SWAP = 3'h1,
    NSX_OP_DIR = 3'h2,
    NSX_OP_LXOR = 3'h3,
    NSX_OP_RXOR = 3'h4
  } nsx_op_e;
endpackage

// File: rtl/nsx_alu_if.sv
// Purpose: Carrier between the executor and its data unit
// Assumes: Purely combinational answer from the data unit
// Notes: Core drives operation and operands, data unit returns result and zero
`timescale 1ns/10ps
interface nsx_alu_if;
  import nsx_pkg::*;
  nsx_op_e op;
  logic [NSX_DATA_W-1:0] acc;
  logic [NSX_DATA_W-1:0] opnd;
  logic [NSX_DATA_W-1:0] result;
  logic zero;
  modport core (output op, output acc, output opnd, input result, input zero);
  modport unit (input op, input acc, input opnd, output result, output zero);
endinterface

// File: rtl/nsx_alu.sv
// Purpose: Data unit: nibble exchange, exclusive-OR, accumulator pass
// Assumes: Operands stable for the whole process phase
// Notes: Combinational; the core registers its answers
`timescale 1ns/10ps
module nsx_alu
  import nsx_pkg::*;
(
  nsx_alu_if.unit bus // Operation, operands and answer
);
  // Result per operation
  always_comb begin
    case (bus.op)
      NSX_OP_SWAP: bus.result = {bus.opnd[3:0], bus.opnd[7:4]}; // see RULE1
      NSX_OP_LXOR: bus.result = bus.acc ^ bus.opnd; // see RULE3
      NSX_OP_RXOR: bus.result = bus.acc ^ bus.opnd; // see RULE5
      NSX_OP_DIR: bus.result = bus.acc; // see RULE2
      default: bus.result = NSX_ZERO_BYTE;
    endcase
  end

  // Zero test of the eight-bit result
  assign bus.zero = (bus.result == NSX_ZERO_BYTE); // see RULE12
endmodule

// File: rtl/nsx_exec.sv
// Purpose: Decode and run nibble exchange, direction load and two exclusive-OR forms
// Assumes: instr held valid while phase shows Q1; file_rd_data answers file_rd_addr in the same cycle
// Notes: One clock per phase, four phases per instruction, phases run free from reset
//
// Contract
// RULE1: Swap nibbles of source, flags untouched
// RULE2: Direction load copies accumulator, selector 5..7
// RULE3: Literal XOR accumulator, result to accumulator
// RULE4: Literal XOR opcode 111010, zero flag only
// RULE5: Register XOR accumulator with file register
// RULE6: Register XOR opcode 000110, d, address
// RULE7: Selector 0 writes accumulator, file untouched
// RULE8: Selector 1 writes back file register
// RULE9: Four phases: decode, read, process, write
// RULE10: Literal operand taken from instruction word
// RULE11: Seven-bit address, one-bit destination selector
// RULE12: Zero flag set exactly when result zero
`timescale 1ns/10ps
module nsx_exec
  import nsx_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic srst, // Synchronous reset, active high
  input wire logic [NSX_WORD_W-1:0] instr, // Instruction word, sampled in Q1
  input wire logic [NSX_DATA_W-1:0] file_rd_data, // File register read data
  output logic [3:0] phase, // One-hot phase Q1..Q4
  output logic [NSX_ADDR_W-1:0] file_rd_addr, // File register read address
  output logic file_wr_en, // File register write strobe, Q4
  output logic [NSX_ADDR_W-1:0] file_wr_addr, // File register write address
  output logic [NSX_DATA_W-1:0] file_wr_data, // File register write data
  output logic dir_wr_en, // Direction register write strobe, Q4
  output logic [NSX_DIR_SEL_W-1:0] dir_wr_sel, // Direction register selector
  output logic [NSX_DATA_W-1:0] dir_wr_data, // Direction register data
  output logic [NSX_DATA_W-1:0] accum, // Accumulator
  output logic zero_flag, // Zero status flag
  output logic instr_done, // Pulse in Q1 after a write phase
  output logic instr_foreign // Pulse in Q2 for a word not handled here
);
  nsx_phase_e state;
  nsx_op_e op;
  nsx_op_e next_op;
  logic dest;
  logic next_dest;
  logic [NSX_WORD_W-1:0] ir;
  logic [NSX_DATA_W-1:0] ir_lit;
  logic [NSX_DATA_W-1:0] opnd;
  logic [NSX_DATA_W-1:0] result;
  logic result_zero;
  logic [5:0] opc;
  logic [NSX_DIR_SEL_W-1:0] dir_field;
  logic file_op;
  nsx_alu_if alu_bus ();

  assign opc = instr[NSX_OPC_MSB:NSX_OPC_LSB];
  assign dir_field = instr[NSX_DIR_SEL_W-1:0];
  assign ir_lit = ir[NSX_DATA_W-1:0];
  assign file_op = (op == NSX_OP_SWAP) || (op == NSX_OP_RXOR);
  assign phase = state;

  // Phase sequencer, free running so every instruction takes exactly four clocks
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= NSX_Q1;
    end else begin
      case (state)
        NSX_Q1: state <= NSX_Q2; // see RULE9
        NSX_Q2: state <= NSX_Q3;
        NSX_Q3: state <= NSX_Q4;
        NSX_Q4: state <= NSX_Q1;
        default: state <= NSX_Q1;
      endcase
    end
  end

  // Opcode match; direction load outside 5..7 falls through as foreign
  always_comb begin
    next_op = NSX_OP_NONE;
    next_dest = 1'b0;
    if (opc == NSX_OPC_SWAP) begin
      next_op = NSX_OP_SWAP; // see RULE1
      next_dest = instr[NSX_DEST_BIT]; // see RULE11
    end else if (opc == NSX_OPC_RXOR) begin
      next_op = NSX_OP_RXOR; // see RULE6
      next_dest = instr[NSX_DEST_BIT];
    end else if (opc == NSX_OPC_LXOR) begin
      next_op = NSX_OP_LXOR; // see RULE4
    end else if (instr[NSX_OPC_MSB:NSX_DIR_OPC_LSB] == NSX_OPC_DIR) begin
      if (dir_field >= NSX_DIR_MIN && dir_field <= NSX_DIR_MAX) begin
        next_op = NSX_OP_DIR; // see RULE2
      end
    end
  end

  // Decode phase: capture word, operation, destination and read address
  always_ff @(posedge clock) begin
    if (srst) begin
      ir <= '0;
      op <= NSX_OP_NONE;
      dest <= 1'b0;
      file_rd_addr <= '0;
      instr_foreign <= 1'b0;
    end else begin
      instr_foreign <= 1'b0;
      if (state == NSX_Q1) begin
        ir <= instr; // see RULE9
        op <= next_op;
        dest <= next_dest;
        file_rd_addr <= instr[NSX_ADDR_W-1:0]; // see RULE11
        instr_foreign <= (next_op == NSX_OP_NONE);
      end
    end
  end

  // Read phase: literal comes from the word, otherwise from the file register
  always_ff @(posedge clock) begin
    if (srst) begin
      opnd <= '0;
    end else if (state == NSX_Q2) begin
      if (op == NSX_OP_LXOR) begin
        opnd <= ir_lit; // see RULE10
      end else begin
        opnd <= file_rd_data;
      end
    end
  end

  // Data unit sees stable operands throughout the process phase
  assign alu_bus.op = op;
  assign alu_bus.acc = accum;
  assign alu_bus.opnd = opnd;

  nsx_alu u_alu (
    .bus(alu_bus)
  );

  // Process phase: register the answer and arm the write strobes for Q4
  always_ff @(posedge clock) begin
    if (srst) begin
      result <= '0;
      result_zero <= 1'b0;
      file_wr_en <= 1'b0;
      file_wr_addr <= '0;
      file_wr_data <= '0;
      dir_wr_en <= 1'b0;
      dir_wr_sel <= '0;
      dir_wr_data <= '0;
    end else if (state == NSX_Q3) begin
      result <= alu_bus.result;
      result_zero <= alu_bus.zero;
      file_wr_en <= file_op && dest; // see RULE8
      file_wr_addr <= ir[NSX_ADDR_W-1:0];
      file_wr_data <= alu_bus.result;
      dir_wr_en <= (op == NSX_OP_DIR); // see RULE2
      dir_wr_sel <= ir[NSX_DIR_SEL_W-1:0];
      dir_wr_data <= accum;
    end else begin
      // Strobes last exactly the write phase
      file_wr_en <= 1'b0;
      dir_wr_en <= 1'b0;
    end
  end

  // Write phase: accumulator and zero flag commit at the end of Q4
  always_ff @(posedge clock) begin
    if (srst) begin
      accum <= NSX_ACC_RST;
      zero_flag <= NSX_ZERO_RST;
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (state == NSX_Q4) begin
        instr_done <= 1'b1;
        if (op == NSX_OP_LXOR || (file_op && !dest)) begin
          accum <= result; // see RULE7
        end
        // Swap and direction load leave status alone
        if (op == NSX_OP_LXOR || op == NSX_OP_RXOR) begin
          zero_flag <= result_zero; // see RULE12
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_phase_order;
    state == NSX_Q1 |=> state == NSX_Q2 ##1 state == NSX_Q3 ##1 state == NSX_Q4 ##1 state == NSX_Q1;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken"); // see RULE9

  property p_swap_write;
    state == NSX_Q4 && op == NSX_OP_SWAP && dest |-> file_wr_en && file_wr_data == {opnd[3:0], opnd[7:4]};
  endproperty
  a_swap_write: assert property (p_swap_write) else $error("swap result wrong"); // see RULE1

  property p_no_flag_change;
    state == NSX_Q4 && (op == NSX_OP_SWAP || op == NSX_OP_DIR) |=> $stable(zero_flag);
  endproperty
  a_no_flag_change: assert property (p_no_flag_change) else $error("flag changed"); // see RULE1

  property p_dir_load;
    state == NSX_Q4 && op == NSX_OP_DIR |-> dir_wr_en && dir_wr_data == accum && dir_wr_sel >= NSX_DIR_MIN;
  endproperty
  a_dir_load: assert property (p_dir_load) else $error("direction load wrong"); // see RULE2

  property p_lxor_acc;
    state == NSX_Q4 && op == NSX_OP_LXOR |=> accum == ($past(accum) ^ $past(ir_lit));
  endproperty
  a_lxor_acc: assert property (p_lxor_acc) else $error("literal xor wrong"); // see RULE3

  property p_lxor_decode;
    state == NSX_Q1 && opc == NSX_OPC_LXOR |=> op == NSX_OP_LXOR && !dest;
  endproperty
  a_lxor_decode: assert property (p_lxor_decode) else $error("literal xor not decoded"); // see RULE4

  property p_rxor_result;
    state == NSX_Q4 && op == NSX_OP_RXOR |-> result == (accum ^ opnd);
  endproperty
  a_rxor_result: assert property (p_rxor_result) else $error("register xor wrong"); // see RULE5

  property p_rxor_decode;
    state == NSX_Q1 && opc == NSX_OPC_RXOR |=> op == NSX_OP_RXOR && dest == $past(instr[NSX_DEST_BIT]);
  endproperty
  a_rxor_decode: assert property (p_rxor_decode) else $error("register xor not decoded"); // see RULE6

  property p_dest_acc;
    state == NSX_Q4 && file_op && !dest |-> !file_wr_en ##1 accum == $past(result);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("selector 0 misrouted"); // see RULE7

  property p_dest_file;
    state == NSX_Q4 && file_op && dest |-> file_wr_en && file_wr_addr == ir[NSX_ADDR_W-1:0] ##1 $stable(accum);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("selector 1 misrouted"); // see RULE8

  property p_lit_operand;
    state == NSX_Q3 && op == NSX_OP_LXOR |-> opnd == ir_lit;
  endproperty
  a_lit_operand: assert property (p_lit_operand) else $error("literal operand wrong"); // see RULE10

  property p_rd_addr;
    state == NSX_Q2 |-> file_rd_addr == ir[NSX_ADDR_W-1:0];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address wrong"); // see RULE11

  property p_zero_flag;
    state == NSX_Q4 && (op == NSX_OP_LXOR || op == NSX_OP_RXOR) |=> zero_flag == ($past(result) == NSX_ZERO_BYTE);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // see RULE12

  c_swap_file: cover property (state == NSX_Q4 && op == NSX_OP_SWAP && dest);
  c_lxor_zero: cover property (state == NSX_Q4 && op == NSX_OP_LXOR && result_zero);
  c_rxor_acc: cover property (state == NSX_Q4 && op == NSX_OP_RXOR && !dest);
  c_dir_load: cover property (dir_wr_en);
endmodule

// File: dv/test_nibble_swap_xor_dir_exec.sv
// Purpose: Self-checking bench for the nibble exchange, direction load and exclusive-OR executor
// Assumes: Phases free-run from reset; a foreign word fills every cycle not under test
// Notes: Bench keeps its own accumulator and zero flag model, built from the opcode patterns
`timescale 1ns/10ps
module test_nibble_swap_xor_dir_exec
  import nsx_pkg::*;
;
  logic clock;
  logic srst;
  logic [13:0] instr;
  logic [7:0] file_rd_data;
  logic [3:0] phase;
  logic [6:0] file_rd_addr;
  logic file_wr_en;
  logic [6:0] file_wr_addr;
  logic [7:0] file_wr_data;
  logic dir_wr_en;
  logic [2:0] dir_wr_sel;
  logic [7:0] dir_wr_data;
  logic [7:0] accum;
  logic zero_flag;
  logic instr_done;
  logic instr_foreign;
  logic [7:0] acc;
  logic z;
  int error_cnt = 0;
  int n_compared = 0;

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

  nsx_exec i_dut (
    .clock(clock),
    .srst(srst),
    .instr(instr),
    .file_rd_data(file_rd_data),
    .phase(phase),
    .file_rd_addr(file_rd_addr),
    .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data),
    .dir_wr_en(dir_wr_en),
    .dir_wr_sel(dir_wr_sel),
    .dir_wr_data(dir_wr_data),
    .accum(accum),
    .zero_flag(zero_flag),
    .instr_done(instr_done),
    .instr_foreign(instr_foreign)
  );

  // Free-running core clock, 10 ns period
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One word through all four phases; the word is withdrawn after Q1 so a repeat never sneaks in
  task automatic exec(input logic [13:0] w, input logic [7:0] d);
    logic [7:0] res;
    logic is_f;
    logic wd;
    logic fgn;
    logic wf;
    int n;
    n = 0;
    is_f = (w[13:8] === NSX_OPC_SWAP) || (w[13:8] === NSX_OPC_RXOR);
    wd = (w[13:3] === NSX_OPC_DIR) && (w[2:0] >= NSX_DIR_MIN);
    fgn = !is_f && !wd && (w[13:8] !== NSX_OPC_LXOR);
    wf = is_f && w[7];
    res = (w[13:8] === NSX_OPC_SWAP) ? {d[3:0], d[7:4]} : (w[13:8] === NSX_OPC_RXOR) ? acc ^ d : acc ^ w[7:0];
    // Read phase only once it has settled, then start the word on the edge that opens Q1
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (phase !== 4'h8 && n < 8);
    @(posedge clock);
    instr <= w;
    file_rd_data <= d;
    @(posedge clock);
    instr <= 14'h0000;
    #1;
    `CHK("phase", 4'h2, phase)
    `CHK("instr_foreign", fgn, instr_foreign)
    if (is_f) `CHK("file_rd_addr", w[6:0], file_rd_addr)
    @(posedge clock);
    @(posedge clock);
    #1;
    `CHK("file_wr_en", wf, file_wr_en)
    if (wf) `CHK("file_wr_addr", w[6:0], file_wr_addr)
    if (wf) `CHK("file_wr_data", res, file_wr_data)
    `CHK("dir_wr_en", wd, dir_wr_en)
    if (wd) `CHK("dir_wr_sel", w[2:0], dir_wr_sel)
    if (wd) `CHK("dir_wr_data", acc, dir_wr_data)
    if (!fgn && !wd && !wf) acc = res;
    if (!fgn && !wd && w[13:8] !== NSX_OPC_SWAP) z = (res == 8'h00);
    @(posedge clock);
    #1;
    `CHK("accum", acc, accum)
    `CHK("zero_flag", z, zero_flag)
    `CHK("instr_done", 1'b1, instr_done)
  endtask

  task automatic t_reset();
    @(posedge clock);
    #1;
    `CHK("phase", 4'h2, phase)
    `CHK("accum", NSX_ACC_RST, accum)
    `CHK("zero_flag", NSX_ZERO_RST, zero_flag)
  endtask

  // Both destinations, highest address; flags must survive a swap
  task automatic t_swap();
    exec(14'h0E12, 8'hA5);
    exec(14'h0EFF, 8'h3C);
  endtask

  // Read data is a decoy: the literal must win
  task automatic t_lxor();
    exec(14'h3A5A, 8'h55);
    exec(14'h0E00, 8'h01);
    exec(14'h3AFF, 8'h55);
    exec(14'h3A00, 8'hFF);
  endtask

  task automatic t_rxor();
    exec(14'h0600, 8'hEF);
    exec(14'h06FF, 8'h81);
    exec(14'h06C5, 8'h00);
  endtask

  // Every selector, the illegal ones refused, plus bit 3 set
  task automatic t_dir();
    exec(14'h3AC3, 8'h00);
    for (int s = 0; s < 8; s++) begin
      exec({NSX_OPC_DIR, 3'(s)}, 8'h00);
    end
    exec(14'h0068, 8'h00);
  endtask

  // Reset in mid-run with a non-zero accumulator, then a first word right after release
  task automatic t_reset_mid();
    @(posedge clock);
    srst <= 1'b1;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    acc = NSX_ACC_RST;
    z = NSX_ZERO_RST;
    t_reset();
    exec(14'h3A00, 8'h00);
  endtask

  // Hang guard, far beyond the 170 or so cycles needed
  initial begin
    #50000;
    error_cnt++;
    close_out();
  end

  initial begin
    srst = 1'b1;
    instr = 14'h0000;
    file_rd_data = 8'h00;
    acc = NSX_ACC_RST;
    z = NSX_ZERO_RST;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_swap();
    t_lxor();
    t_rxor();
    t_dir();
    t_reset_mid();
    close_out();
  end
endmodule
